/* File: design/spicb_ctrl.sv */
// spicb_ctrl: control, rate and pin steering of the serial port
`timescale 1ns/10ps
// Overview of operation
// R1: receive or fault flag raises irq when enabled
// R2: disable forces idle and clears status
// R3: pins driven only while port enabled
// R4: tx empty flag raises irq when enabled
// R5: role bit picks master; change forces idle
// R6: polarity sets clock idle level, both ends
// R7: phase picks odd or even sampling edges
// R8: master config change aborts transfer; irq enable, tx empty irq enable and stop in wait changes do not abort
// R9: bit order selectable, data register unchanged
// R10: master select pin per fault and output
// R11: slave select pin always an input
// R12: bidir output enable gates active data pin
// R13: bidir enable change aborts only in bidir
// R14: master pin use per pin control
// R15: slave pin use per pin control
// R16: stop in wait halts clock generation
// R17: rate register holds preselect and select
// R18: unused bits ignore writes, read zero
// R19: master clock is bus clock over divisor
// R20: divisor is (pre+1) times 2^(sel+1)
// R21: all config registers reset to zero
module spicb_ctrl #(
    parameter int CNT_W = spicb_pkg::HALF_CNT_W
) (
    input  wire logic                        core_clk_in,
    input  wire logic                        rstn_in,
    input  wire logic [spicb_pkg::ADDR_W-1:0] avs_address_in,
    input  wire logic                        avs_read_in,
    input  wire logic                        avs_write_in,
    input  wire logic [31:0]                 avs_writedata_in,
    input  wire logic [3:0]                  avs_byteenable_in,
    output logic      [31:0]                 avs_readdata_out,
    output logic                             avs_waitrequest_out,
    input  wire logic                        rx_complete_flag_in,
    input  wire logic                        mode_fault_flag_in,
    input  wire logic                        tx_empty_flag_in,
    input  wire logic                        wait_mode_in,
    input  wire logic                        sck_run_in,
    input  wire logic                        serial_tx_in,
    input  wire logic                        ss_drive_in,
    input  wire logic                        mosi_pin_in,
    input  wire logic                        miso_pin_in,
    input  wire logic                        ss_n_pin_in,
    input  wire logic                        sck_pin_in,
    output spicb_pkg::spicb_cfg_s            cfg_out,
    output spicb_pkg::spicb_pins_s           pins_out,
    output logic                             serial_rx_out,
    output logic                             slave_sck_out,
    output logic                             mode_fault_detect_out,
    output logic                             sample_strobe_out,
    output logic                             force_idle_out,
    output logic                             status_clear_out,
    output logic                             irq_out
);
    // elaboration check: counter must hold the largest half period
    if (CNT_W < spicb_pkg::HALF_CNT_W) begin : g_cnt_w_check
        $error("CNT_W too small for largest half period");
    end

    // half period in bus cycles; full divisor is twice this
    function automatic logic [CNT_W-1:0] half_period(input logic [7:0] br);
        logic [CNT_W-1:0] p;
        p = CNT_W'(br[spicb_pkg::PRE_LSB +: 3]) + CNT_W'(1);
        return p << br[spicb_pkg::SEL_LSB +: 3]; // R20
    endfunction

    // bus slave and config registers
    logic [7:0]  ctl1_r, ctl1_nxt;
    logic [7:0]  ctl2_r, ctl2_nxt;
    logic [7:0]  rate_r, rate_nxt;
    logic        ack_r, ack_nxt;
    logic        wreq_r, wreq_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        abort_r, abort_nxt;
    logic        req;
    logic        wr_acc;
    logic [7:0]  wbyte;

    assign req = avs_read_in | avs_write_in;
    assign wr_acc = avs_write_in & ack_r & avs_byteenable_in[0];
    assign wbyte = avs_writedata_in[7:0];

    always_comb begin
        ctl1_nxt  = ctl1_r;
        ctl2_nxt  = ctl2_r;
        rate_nxt  = rate_r;
        ack_nxt   = req & ~ack_r;
        wreq_nxt  = ~(req & ~ack_r);
        rdata_nxt = rdata_r;
        if (req & ~ack_r) begin
            case (avs_address_in)
                spicb_pkg::ADDR_CTRL_ONE: rdata_nxt = {24'h000000, ctl1_r};
                spicb_pkg::ADDR_CTRL_TWO: rdata_nxt = {24'h000000, ctl2_r};
                spicb_pkg::ADDR_RATE_SEL: rdata_nxt = {24'h000000, rate_r};
                default:                  rdata_nxt = 32'h00000000;
            endcase
        end
        if (wr_acc) begin
            case (avs_address_in)
                spicb_pkg::ADDR_CTRL_ONE: ctl1_nxt = wbyte;
                spicb_pkg::ADDR_CTRL_TWO:
                    ctl2_nxt = wbyte & spicb_pkg::MASK_CTRL_TWO; // R18
                spicb_pkg::ADDR_RATE_SEL:
                    rate_nxt = wbyte & spicb_pkg::MASK_RATE_SEL; // R17 R18
                default: ;
            endcase
        end
    end

    // abort on role change anytime, on format, fault, pin and rate changes as master (not irq or wait bits)
    always_comb begin
        logic master;
        logic [7:0] d1;
        logic [7:0] d2;
        master = ctl1_r[spicb_pkg::B_ROLE];
        d1 = ctl1_nxt ^ ctl1_r;
        d2 = ctl2_nxt ^ ctl2_r;
        abort_nxt = d1[spicb_pkg::B_ROLE]; // R5
        if (master) begin
            abort_nxt = abort_nxt | d1[spicb_pkg::B_CLOCK_POLARITY]
                      | d1[spicb_pkg::B_CLOCK_PHASE] | d1[spicb_pkg::B_SELECT_OUTPUT_ENABLE]
                      | d1[spicb_pkg::B_LSBF] | d2[spicb_pkg::B_MODE_FAULT_ENABLE]
                      | d2[spicb_pkg::B_PINCTL]
                      | (rate_nxt != rate_r); // R8
            if (ctl2_r[spicb_pkg::B_PINCTL]) begin
                abort_nxt = abort_nxt | d2[spicb_pkg::B_BIDIR_OUTPUT_ENABLE]; // R13
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            ctl1_r  <= spicb_pkg::RST_CTRL_ONE; // R21
            ctl2_r  <= spicb_pkg::RST_CTRL_TWO;
            rate_r  <= spicb_pkg::RST_RATE_SEL;
            ack_r   <= 1'b0;
            wreq_r  <= 1'b1;
            rdata_r <= 32'h00000000;
            abort_r <= 1'b0;
        end else begin
            ctl1_r  <= ctl1_nxt;
            ctl2_r  <= ctl2_nxt;
            rate_r  <= rate_nxt;
            ack_r   <= ack_nxt;
            wreq_r  <= wreq_nxt;
            rdata_r <= rdata_nxt;
            abort_r <= abort_nxt;
        end
    end

    // own flop so the bus never sees a gate on waitrequest
    assign avs_waitrequest_out = wreq_r;
    assign avs_readdata_out    = rdata_r;
    // bit order only steers the shifter; register layout stays msb at 7
    assign cfg_out = '{
        irq_enable:           ctl1_r[spicb_pkg::B_IRQ_EN],
        system_enable:        ctl1_r[spicb_pkg::B_SYS_EN],
        tx_empty_irq_enable:  ctl1_r[spicb_pkg::B_TXIE],
        role_select:          ctl1_r[spicb_pkg::B_ROLE],
        clock_polarity:       ctl1_r[spicb_pkg::B_CLOCK_POLARITY],
        clock_phase:          ctl1_r[spicb_pkg::B_CLOCK_PHASE],
        select_output_enable: ctl1_r[spicb_pkg::B_SELECT_OUTPUT_ENABLE],
        low_bit_first:        ctl1_r[spicb_pkg::B_LSBF], // R9
        mode_fault_enable:    ctl2_r[spicb_pkg::B_MODE_FAULT_ENABLE],
        bidir_output_enable:  ctl2_r[spicb_pkg::B_BIDIR_OUTPUT_ENABLE],
        stop_in_wait:         ctl2_r[spicb_pkg::B_SWAI],
        bidir_pin_control:    ctl2_r[spicb_pkg::B_PINCTL],
        rate_preselect:       rate_r[spicb_pkg::PRE_LSB +: 3],
        rate_select:          rate_r[spicb_pkg::SEL_LSB +: 3]
    };

    // master clock generator
    spicb_pkg::spicb_gen_e gen_r, gen_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic [4:0]       edge_r, edge_nxt;
    logic             sck_r, sck_nxt;
    logic             smp_r, smp_nxt;
    logic             idle_r, idle_nxt;
    logic             en;
    logic             master;
    logic             halted;

    assign en = ctl1_r[spicb_pkg::B_SYS_EN];
    assign master = ctl1_r[spicb_pkg::B_ROLE];
    assign halted = ctl2_r[spicb_pkg::B_SWAI] & wait_mode_in; // R16

    always_comb begin
        gen_nxt  = gen_r;
        cnt_nxt  = cnt_r;
        edge_nxt = edge_r;
        sck_nxt  = sck_r;
        smp_nxt  = 1'b0;
        idle_nxt = abort_nxt | ~ctl1_nxt[spicb_pkg::B_SYS_EN]; // R2 R5 R8
        case (gen_r)
            spicb_pkg::GEN_IDLE: begin
                cnt_nxt  = '0;
                edge_nxt = 5'h00;
                sck_nxt  = ctl1_r[spicb_pkg::B_CLOCK_POLARITY]; // R6
                if (en & master & sck_run_in & ~abort_r) begin
                    gen_nxt = spicb_pkg::GEN_RUN;
                end
            end
            spicb_pkg::GEN_RUN: begin
                if (~en | ~master | ~sck_run_in | abort_r) begin
                    gen_nxt = spicb_pkg::GEN_IDLE;
                    sck_nxt = ctl1_r[spicb_pkg::B_CLOCK_POLARITY];
                end else if (halted) begin
                    // held, transfer resumes when wait ends
                    cnt_nxt = cnt_r;
                end else if (cnt_r == half_period(rate_r) - CNT_W'(1)) begin
                    cnt_nxt = '0; // R19
                    if (edge_r != spicb_pkg::EDGE_LAST) begin
                        sck_nxt  = ~sck_r;
                        edge_nxt = edge_r + 5'h01;
                        // odd edges at phase 0, even at phase 1
                        smp_nxt  = edge_nxt[0]
                                 ^ ctl1_r[spicb_pkg::B_CLOCK_PHASE]; // R7
                    end
                end else begin
                    cnt_nxt = cnt_r + CNT_W'(1);
                end
            end
            default: gen_nxt = spicb_pkg::GEN_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            gen_r  <= spicb_pkg::GEN_IDLE;
            cnt_r  <= '0;
            edge_r <= 5'h00;
            sck_r  <= 1'b0;
            smp_r  <= 1'b0;
            idle_r <= 1'b1;
        end else begin
            gen_r  <= gen_nxt;
            cnt_r  <= cnt_nxt;
            edge_r <= edge_nxt;
            sck_r  <= sck_nxt;
            smp_r  <= smp_nxt;
            idle_r <= idle_nxt;
        end
    end

    assign sample_strobe_out = smp_r;
    assign force_idle_out    = idle_r;

    // pin steering, interrupt and status clear
    spicb_pkg::spicb_pins_s pins_r, pins_nxt;
    logic rx_r, rx_nxt;
    logic ssck_r, ssck_nxt;
    logic mfd_r, mfd_nxt;
    logic irq_r, irq_nxt;
    logic sclr_r, sclr_nxt;

    always_comb begin
        logic pc;
        logic oe;
        logic mf;
        pc = ctl2_r[spicb_pkg::B_PINCTL];
        oe = ctl2_r[spicb_pkg::B_BIDIR_OUTPUT_ENABLE];
        mf = ctl2_r[spicb_pkg::B_MODE_FAULT_ENABLE];
        pins_nxt = '0;
        pins_nxt.mosi_out = serial_tx_in;
        pins_nxt.miso_out = serial_tx_in;
        pins_nxt.ss_out   = ss_drive_in;
        pins_nxt.sck_out  = sck_r;
        rx_nxt   = 1'b0;
        ssck_nxt = 1'b0;
        mfd_nxt  = 1'b0;
        if (en) begin // R3
            if (master) begin
                pins_nxt.sck_oe  = 1'b1;
                pins_nxt.mosi_oe = ~pc | oe; // R12 R14
                rx_nxt = pc ? mosi_pin_in : miso_pin_in; // R14
                pins_nxt.ss_oe = mf & ctl1_r[spicb_pkg::B_SELECT_OUTPUT_ENABLE]; // R10
                mfd_nxt = mf & ~ctl1_r[spicb_pkg::B_SELECT_OUTPUT_ENABLE] & ~ss_n_pin_in;
            end else begin
                // slave select stays an input in slave mode
                pins_nxt.miso_oe = (~pc | oe) & ~ss_n_pin_in; // R11 R12 R15
                rx_nxt   = pc ? miso_pin_in : mosi_pin_in; // R15
                ssck_nxt = sck_pin_in;
            end
        end
        irq_nxt = en & ((ctl1_r[spicb_pkg::B_IRQ_EN]
                         & (rx_complete_flag_in | mode_fault_flag_in)) // R1
                      | (ctl1_r[spicb_pkg::B_TXIE] & tx_empty_flag_in)); // R4
        sclr_nxt = ~ctl1_nxt[spicb_pkg::B_SYS_EN]; // R2
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            pins_r <= '0;
            rx_r   <= 1'b0;
            ssck_r <= 1'b0;
            mfd_r  <= 1'b0;
            irq_r  <= 1'b0;
            sclr_r <= 1'b1;
        end else begin
            pins_r <= pins_nxt;
            rx_r   <= rx_nxt;
            ssck_r <= ssck_nxt;
            mfd_r  <= mfd_nxt;
            irq_r  <= irq_nxt;
            sclr_r <= sclr_nxt;
        end
    end

    assign pins_out              = pins_r;
    assign serial_rx_out         = rx_r;
    assign slave_sck_out         = ssck_r;
    assign mode_fault_detect_out = mfd_r;
    assign irq_out               = irq_r;
    assign status_clear_out      = sclr_r;

    // checks
    irq_rx_fault_a: assert property (@(posedge core_clk_in) // R1
        disable iff (!rstn_in)
        en & ctl1_r[spicb_pkg::B_IRQ_EN] & (rx_complete_flag_in
            | mode_fault_flag_in) |=> irq_r)
        else $error("receive or fault irq missing");
    irq_tx_gate_a: assert property (@(posedge core_clk_in) // R4
        disable iff (!rstn_in)
        ~ctl1_r[spicb_pkg::B_IRQ_EN] & ~ctl1_r[spicb_pkg::B_TXIE]
            |=> ~irq_r)
        else $error("irq raised while both enables clear");
    disable_idle_a: assert property (@(posedge core_clk_in) // R2
        disable iff (!rstn_in)
        ~ctl1_nxt[spicb_pkg::B_SYS_EN] |=> idle_r & sclr_r
            ##1 gen_r == spicb_pkg::GEN_IDLE)
        else $error("disable did not force idle and clear");
    pins_released_a: assert property (@(posedge core_clk_in) // R3
        disable iff (!rstn_in)
        ~en |=> ~pins_r.mosi_oe & ~pins_r.miso_oe & ~pins_r.ss_oe
            & ~pins_r.sck_oe)
        else $error("pin driven while disabled");
    role_abort_a: assert property (@(posedge core_clk_in) // R5
        disable iff (!rstn_in)
        wr_acc & (ctl1_nxt[spicb_pkg::B_ROLE] != master) |=> idle_r)
        else $error("role change did not force idle");
    sck_idle_lvl_a: assert property (@(posedge core_clk_in) // R6
        disable iff (!rstn_in)
        gen_r == spicb_pkg::GEN_IDLE
            |=> sck_r == $past(ctl1_r[spicb_pkg::B_CLOCK_POLARITY]))
        else $error("clock idle level wrong");
    sample_edge_a: assert property (@(posedge core_clk_in) // R7
        disable iff (!rstn_in)
        smp_r |-> edge_r[0] == ~$past(ctl1_r[spicb_pkg::B_CLOCK_PHASE]))
        else $error("sampling on wrong edge parity");
    rate_abort_a: assert property (@(posedge core_clk_in) // R8
        disable iff (!rstn_in)
        master & (rate_nxt != rate_r) |=> idle_r
            ##1 gen_r == spicb_pkg::GEN_IDLE)
        else $error("rate change did not abort");
    reserved_zero_a: assert property (@(posedge core_clk_in) // R18
        disable iff (!rstn_in)
        ((ctl2_r & ~spicb_pkg::MASK_CTRL_TWO) == 8'h00)
            && ((rate_r & ~spicb_pkg::MASK_RATE_SEL) == 8'h00))
        else $error("reserved bit set");
    slave_ss_in_a: assert property (@(posedge core_clk_in) // R11
        disable iff (!rstn_in)
        ~master |=> ~pins_r.ss_oe)
        else $error("select driven in slave mode");
    wait_halt_a: assert property (@(posedge core_clk_in) // R16
        disable iff (!rstn_in)
        gen_r == spicb_pkg::GEN_RUN & halted
            & gen_nxt == spicb_pkg::GEN_RUN |=> $stable(sck_r))
        else $error("clock moved while halted in wait");
endmodule

/* File: common/spicb_pkg.sv */
// spicb_pkg: register map, field layout and carrier types of the port
package spicb_pkg;
    localparam logic [7:0] IDX_CTRL_ONE   = 8'hE8;
    localparam logic [7:0] IDX_CTRL_TWO   = 8'hE9;
    localparam logic [7:0] IDX_RATE_SEL   = 8'hEA;
    localparam logic [9:0] ADDR_CTRL_ONE  = {IDX_CTRL_ONE, 2'b00};
    localparam logic [9:0] ADDR_CTRL_TWO  = {IDX_CTRL_TWO, 2'b00};
    localparam logic [9:0] ADDR_RATE_SEL  = {IDX_RATE_SEL, 2'b00};
    localparam int         ADDR_W         = 10;

    // control one
    localparam int B_IRQ_EN   = 7;
    localparam int B_SYS_EN   = 6;
    localparam int B_TXIE     = 5;
    localparam int B_ROLE     = 4;
    localparam int B_CLOCK_POLARITY     = 3;
    localparam int B_CLOCK_PHASE     = 2;
    localparam int B_SELECT_OUTPUT_ENABLE     = 1;
    localparam int B_LSBF     = 0;
    // control two
    localparam int B_MODE_FAULT_ENABLE   = 4;
    localparam int B_BIDIR_OUTPUT_ENABLE  = 3;
    localparam int B_SWAI     = 1;
    localparam int B_PINCTL   = 0;
    // rate select
    localparam int PRE_LSB    = 4;
    localparam int SEL_LSB    = 0;

    localparam logic [7:0] MASK_CTRL_ONE  = 8'hFF;
    localparam logic [7:0] MASK_CTRL_TWO  = 8'h1B;
    localparam logic [7:0] MASK_RATE_SEL  = 8'h77;
    localparam logic [7:0] RST_CTRL_ONE   = 8'h00;
    localparam logic [7:0] RST_CTRL_TWO   = 8'h00;
    localparam logic [7:0] RST_RATE_SEL   = 8'h00;
    localparam int         HALF_CNT_W     = 11;
    localparam logic [4:0] EDGE_LAST      = 5'h10;

    typedef enum logic {
        GEN_IDLE = 1'b0,
        GEN_RUN  = 1'b1
    } spicb_gen_e;

    typedef struct packed {
        logic       irq_enable;
        logic       system_enable;
        logic       tx_empty_irq_enable;
        logic       role_select;
        logic       clock_polarity;
        logic       clock_phase;
        logic       select_output_enable;
        logic       low_bit_first;
        logic       mode_fault_enable;
        logic       bidir_output_enable;
        logic       stop_in_wait;
        logic       bidir_pin_control;
        logic [2:0] rate_preselect;
        logic [2:0] rate_select;
    } spicb_cfg_s;

    typedef struct packed {
        logic mosi_out;
        logic mosi_oe;
        logic miso_out;
        logic miso_oe;
        logic ss_out;
        logic ss_oe;
        logic sck_out;
        logic sck_oe;
    } spicb_pins_s;
endpackage

/* File: verif/spicb_peer.sv */
// spicb_peer: far-side peripheral model resolving the four port lines
`timescale 1ns/10ps
module spicb_peer (
    input  wire logic                   clk_in,
    input  wire spicb_pkg::spicb_pins_s dut_pins_in,
    input  wire logic [3:0]             drv_en_in,
    input  wire logic [3:0]             drv_val_in,
    output logic      [3:0]             lvl_out
);
    // lines: 3 mosi, 2 miso, 1 select (pulled up), 0 clock
    logic [3:0] oe;
    logic [3:0] dv;
    logic [3:0] last_r;
    assign oe = {dut_pins_in.mosi_oe, dut_pins_in.miso_oe,
                 dut_pins_in.ss_oe, dut_pins_in.sck_oe};
    assign dv = {dut_pins_in.mosi_out, dut_pins_in.miso_out,
                 dut_pins_in.ss_out, dut_pins_in.sck_out};
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (oe[i])
                lvl_out[i] = dv[i];
            else if (drv_en_in[i])
                lvl_out[i] = drv_val_in[i];
            else if (i == 1)
                lvl_out[i] = 1'h1;
            else
                // floating line must not look like a held value
                lvl_out[i] = ~last_r[i];
        end
    end
    always_ff @(posedge clk_in) begin
        last_r <= lvl_out;
    end
endmodule

/* File: verif/spi_control_and_baud_config_tb.sv */
// spi_control_and_baud_config_tb: register, pin and clock checks
`timescale 1ns/10ps
module spi_control_and_baud_config_tb;
    localparam logic [9:0] C1 = spicb_pkg::ADDR_CTRL_ONE;
    localparam logic [9:0] C2 = spicb_pkg::ADDR_CTRL_TWO;
    localparam logic [9:0] CB = spicb_pkg::ADDR_RATE_SEL;
    localparam logic [7:0] LD [10] = '{8'h58, 8'h54, 8'h52, 8'h51, 8'hD0,
                                       8'h10, 8'h01, 8'h08, 8'h10, 8'h01};
    logic        clk = 1'h0;
    logic        rstn = 1'h0;
    logic [9:0]  addr = 10'h000;
    logic        rd = 1'h0;
    logic        wr = 1'h0;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  be = 4'hF;
    logic [2:0]  flags = 3'h0;
    logic        wait_mode = 1'h0;
    logic        sck_run = 1'h0;
    logic        tx_bit = 1'h1;
    logic        ss_drv = 1'h0;
    logic [3:0]  pen = 4'hF;
    logic [3:0]  pval = 4'h8;
    logic [31:0] rdata;
    logic        waitreq;
    logic [3:0]  lvl;
    spicb_pkg::spicb_cfg_s  cfg;
    spicb_pkg::spicb_pins_s pins;
    logic rx, ssck, mfd, strb, fidle, sclr, irq, seen;
    logic [31:0] rv;
    int miscompares = 0;
    int compares = 0;
    int tog, nstrb, fst, half, last_t;

    always #5 clk = ~clk;

    spicb_ctrl u_dut (
        .core_clk_in(clk), .rstn_in(rstn), .avs_address_in(addr),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(be), .avs_readdata_out(rdata),
        .avs_waitrequest_out(waitreq), .rx_complete_flag_in(flags[2]),
        .mode_fault_flag_in(flags[1]), .tx_empty_flag_in(flags[0]),
        .wait_mode_in(wait_mode), .sck_run_in(sck_run),
        .serial_tx_in(tx_bit), .ss_drive_in(ss_drv),
        .mosi_pin_in(lvl[3]), .miso_pin_in(lvl[2]),
        .ss_n_pin_in(lvl[1]), .sck_pin_in(lvl[0]), .cfg_out(cfg),
        .pins_out(pins), .serial_rx_out(rx), .slave_sck_out(ssck),
        .mode_fault_detect_out(mfd), .sample_strobe_out(strb),
        .force_idle_out(fidle), .status_clear_out(sclr), .irq_out(irq));

    spicb_peer u_peer (.clk_in(clk), .dut_pins_in(pins),
        .drv_en_in(pen), .drv_val_in(pval), .lvl_out(lvl));

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("FAIL %0t: saw %h expected %h", $time, s, e);
        end
    endtask

    task automatic give_verdict();
        if (miscompares == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // one access; no fixed latency assumed, bounded wait
    task automatic acc(input logic w, input logic [9:0] a,
                       input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= ~w;
        wdata <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'h0 && n < 50);
        chk({31'h0, n < 50}, 32'h1);
        rv = rdata;
        wr <= 1'h0;
        rd <= 1'h0;
    endtask

    task automatic pause(input int n);
        repeat (n) @(posedge clk);
    endtask

    // abort shows as a one-cycle pulse, so watch a window
    task automatic idle_win();
        seen = 1'h0;
        repeat (6) begin
            @(posedge clk);
            seen = seen | fidle;
        end
    endtask

    task automatic burst(input logic pol);
        logic p;
        int t;
        tog = 0;
        nstrb = 0;
        fst = 0;
        half = 0;
        t = 0;
        p = pol;
        sck_run <= 1'h1;
        repeat (300) begin
            @(posedge clk);
            t++;
            if (pins.sck_out !== p) begin
                tog++;
                if (tog == 2)
                    half = t - last_t;
                last_t = t;
                p = pins.sck_out;
            end
            if (strb === 1'h1) begin
                nstrb++;
                // strobe leads the registered pin edge by one cycle
                if (fst == 0)
                    fst = tog + 1;
            end
        end
        sck_run <= 1'h0;
    endtask

    initial begin
        #500000;
        miscompares++;
        give_verdict();
    end

    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'h1;
        pause(1);
        chk({waitreq, fidle, sclr, irq}, 4'hE);
        for (int i = 0; i < 3; i++) begin
            acc(1'h0, i == 0 ? C1 : i == 1 ? C2 : CB, 8'h00);
            chk(rv, 32'h0);
            acc(1'h1, i == 0 ? C1 : i == 1 ? C2 : CB, 8'hFF);
            acc(1'h0, i == 0 ? C1 : i == 1 ? C2 : CB, 8'h00);
            chk(rv, i == 0 ? 32'hFF : i == 1 ? 32'h1B : 32'h77);
            acc(1'h1, i == 0 ? C1 : i == 1 ? C2 : CB, 8'h00);
        end
        acc(1'h0, 10'h3AC, 8'h00);
        chk(rv, 32'h0);
        be <= 4'hE;
        acc(1'h1, C1, 8'hFF);
        be <= 4'hF;
        acc(1'h0, C1, 8'h00);
        chk(rv, 32'h0);
        acc(1'h1, CB, 8'h35);
        pause(1);
        chk({cfg.rate_preselect, cfg.rate_select}, 6'h1D);
        for (int e = 0; e < 4; e++) begin
            acc(1'h1, C1, {e[1], 1'h1, e[0], 5'h00});
            for (int f = 0; f < 8; f++) begin
                flags <= f[2:0];
                pause(3);
                chk(irq, (e[1] & (f[2] | f[1])) | (e[0] & f[0]));
            end
        end
        flags <= 3'h0;
        acc(1'h1, C1, 8'h10);
        pause(3);
        chk({pins.mosi_oe, pins.miso_oe, pins.ss_oe, pins.sck_oe}, 0);
        chk(sclr, 1'h1);
        acc(1'h1, C1, 8'h50);
        pause(3);
        chk({sclr, pins.sck_oe, pins.mosi_oe}, 3'h3);
        acc(1'h1, C1, 8'h10);
        idle_win();
        chk({seen, sclr}, 2'h3);
        // far side held: data lines driven, select low, clock idle 0
        for (int k = 0; k < 32; k++) begin
            acc(1'h1, C1, {3'h2, k[4], 2'h0, k[3], 1'h0});
            acc(1'h1, C2, {3'h0, k[2], k[1], 2'h0, k[0]});
            pause(3);
            chk({pins.mosi_oe, pins.miso_oe, pins.ss_oe, pins.sck_oe, mfd},
                {k[4] & (k[0] ? k[1] : 1'h1), ~k[4] & (k[0] ? k[1] : 1'h1),
                 k[4] & k[2] & k[3], k[4], k[4] & k[2] & ~k[3]});
            chk(rx, (k[4] ^ k[0]) ? lvl[2] : lvl[3]);
        end
        acc(1'h1, C2, 8'h00);
        acc(1'h1, C1, 8'h40);
        pval <= 4'h9;
        pause(3);
        chk(ssck, 1'h1);
        pval <= 4'h8;
        acc(1'h1, C1, 8'h48);
        idle_win();
        chk(seen, 1'h0);
        acc(1'h1, C1, 8'h50);
        idle_win();
        chk(seen, 1'h1);
        acc(1'h1, C1, 8'h40);
        idle_win();
        chk(seen, 1'h1);
        for (int i = 0; i < 10; i++) begin
            acc(1'h1, C1, 8'h50);
            acc(1'h1, C2, 8'h00);
            acc(1'h1, CB, 8'h00);
            pause(4);
            acc(1'h1, i < 5 ? C1 : i < 8 ? C2 : CB, LD[i]);
            idle_win();
            chk(seen, i != 4 && i != 7);
        end
        acc(1'h1, C1, 8'h51);
        pause(1);
        chk(cfg, {8'h51, 4'h0, 6'h01});
        acc(1'h1, C2, 8'h01);
        pause(4);
        acc(1'h1, C2, 8'h09);
        idle_win();
        chk(seen, 1'h1);
        acc(1'h1, C2, 8'h00);
        for (int c = 0; c < 4; c++) begin
            acc(1'h1, C1, {4'h5, c[1], c[0], 2'h0});
            acc(1'h1, CB, {2'h0, c[1:0], 3'h0, c[0]});
            pause(4);
            chk(pins.sck_out, c[1]);
            burst(c[1]);
            chk(tog, 16);
            chk(nstrb, 8);
            chk(fst, 1 + c[0]);
            chk(half, (c + 1) << c[0]);
            pause(6);
            chk(pins.sck_out, c[1]);
        end
        wait_mode <= 1'h1;
        for (int w = 0; w < 2; w++) begin
            acc(1'h1, C2, {6'h00, w[0], 1'h0});
            pause(4);
            burst(1'h1);
            chk(tog, w == 1 ? 0 : 16);
        end
        give_verdict();
    end
endmodule
